// ===== bench/pab_pads.sv
// Pad and board model for one 8-bit port
`timescale 1ns/1ps
module pab_pads (
  input wire logic clock,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_q = 8'h00;
  // Undriven, unpulled pads wander every cycle
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end
  // Pin driver first, then board stimulus, then pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                  (~pad_oe & ~ext_en & (pull_en | float_q));
endmodule : pab_pads

// ===== bench/pab_top_assertions.sv
// Port-level checks for the port A/B override block
`timescale 1ns/1ps
module pab_top_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [7:0] porta_dir,
  input wire logic [7:0] porta_out,
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portb_out,
  input wire logic t2_compare_a_en,
  input wire logic t2_compare_a_out,
  input wire logic [3:0] lcd_segment_line,
  input wire logic [3:0] lcd_common_line,
  input wire logic [7:0] porta_pad_oe,
  input wire logic [7:0] porta_pullup,
  input wire logic [7:0] porta_analog_en,
  input wire logic [7:0] porta_analog_out,
  input wire logic [7:0] portb_pad_out,
  input wire logic [7:0] portb_pad_oe,
  input wire logic [7:0] portb_pullup,
  input wire logic [7:0] portb_in,
  input wire logic [7:1] pin_change_source
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus handshake timing
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  // Port B pin-change, compare outputs and pull-ups
  a_pcint_map: assert property (pin_change_source == portb_in[7:1])
    else $error("pin change sources differ from port B inputs");
  a_pb_dir_plain: assert property (1'b1 |=>
    portb_pad_oe[7:4] == $past(portb_dir[7:4])) else $error("PB7:4 oe");
  a_pb_cmp_val: assert property (t2_compare_a_en |=>
    portb_pad_out[7] == $past(t2_compare_a_out)) else $error("PB7 value");
  a_pb_pull_rule: assert property (1'b1 |=> (portb_pullup[7:4] &
    ~$past(~portb_dir[7:4] & portb_out[7:4])) == 4'h0) else $error("PB pull");
  // Port A pull-up rule and LCD overrides
  a_pa_pull_rule: assert property (1'b1 |=> (porta_pullup &
    ~$past(~porta_dir & porta_out)) == 8'h00) else $error("PA pull-up");
  a_pa_lcd_force: assert property ((porta_analog_en &
    (porta_pad_oe | porta_pullup)) == 8'h00) else $error("LCD pin driven");
  a_pa_duty_order: assert property ((porta_analog_en[3:1] &
    ~porta_analog_en[2:0]) == 3'h0 && porta_analog_en[7:4] ==
    {4{porta_analog_en[0]}}) else $error("LCD duty override order");
  a_lcd_route: assert property (1'b1 |=> porta_analog_out ==
    $past({lcd_segment_line, lcd_common_line})) else $error("LCD route");
endmodule : pab_top_chk
bind pab_top pab_top_chk u_chk (.*);

// ===== bench/tb_pab_top.sv
// Register-level testbench for the port A/B override block
`timescale 1ns/1ps
module tb_pab_top
  import pab_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic sleep = 1'b0, pin_change_group_enable = 1'b0;
  logic spi_slave_out = 1'b0, spi_master_out = 1'b0, spi_sck_out = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF, cmp_en = 4'h0, cmp_val = 4'h0;
  logic [3:0] lcd_segment_line = 4'h9, lcd_common_line = 4'h6;
  logic [7:0] porta_dir = 8'h00, porta_out = 8'h00, pin_change_mask = 8'h00;
  logic [7:0] portb_dir = 8'h00, portb_out = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, porta_pad_in, portb_pad_in, rd, ex;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, spi_master_in, spi_slave_in, spi_sck_in;
  logic spi_slave_select_n;
  logic [7:0] porta_pad_out, porta_pad_oe, porta_pullup, porta_analog_en;
  logic [7:0] porta_analog_out, portb_pad_out, portb_pad_oe, portb_pullup;
  logic [7:0] porta_in, portb_in;
  logic [7:1] pin_change_source;
  int bad_count = 0, cmp_count = 0, d;
  pab_top uut (.t2_compare_a_en(cmp_en[3]), .t2_compare_a_out(cmp_val[3]),
    .t1_compare_b_en(cmp_en[2]), .t1_compare_b_out(cmp_val[2]),
    .t1_compare_a_en(cmp_en[1]), .t1_compare_a_out(cmp_val[1]),
    .t0_compare_a_en(cmp_en[0]), .t0_compare_a_out(cmp_val[0]), .*);
  pab_pads pads_a (.clock(clock), .pad_out(porta_pad_out),
    .pad_oe(porta_pad_oe), .pull_en(porta_pullup), .ext_en(8'h00),
    .ext_val(8'h00), .pad_in(porta_pad_in));
  pab_pads pads_b (.clock(clock), .pad_out(portb_pad_out),
    .pad_oe(portb_pad_oe), .pull_en(portb_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(portb_pad_in));
  // 250 MHz clock
  always #2 clock = ~clock;
  task conclude;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task settle;
    repeat (6) @(posedge clock);
  endtask : settle
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, PAB_ADDR_CTRL, 8'h00);
    chk("ctrl reset", 32'h00, rd);
    bus(1'b1, PAB_ADDR_CTRL, 8'hFF);
    bus(1'b0, PAB_ADDR_CTRL, 8'h00);
    chk("ctrl bits", 32'h93, rd);
    avs_byteenable <= 4'hE;
    bus(1'b1, PAB_ADDR_CTRL, 8'h00);
    avs_byteenable <= 4'hF;
    bus(1'b0, PAB_ADDR_CTRL, 8'h00);
    chk("lane0 off", 32'h93, rd);
    bus(1'b1, PAB_ADDR_CTRL, 8'h00);
    porta_out <= 8'hFF;
    portb_out <= 8'hFF;
    settle;
    chk("pa pull", 32'hFF, porta_pullup);
    chk("pb pull", 32'hFF, portb_pullup);
    bus(1'b1, PAB_ADDR_CTRL, 8'h10);
    settle;
    chk("pa pull off", 32'h00, porta_pullup);
    chk("pb pull off", 32'h00, portb_pullup);
    bus(1'b1, PAB_ADDR_CTRL, 8'h00);
    porta_dir <= 8'hF0;
    porta_out <= 8'hA5;
    settle;
    chk("pa oe", 32'hF0, porta_pad_oe);
    chk("pa out", 32'hA5, porta_pad_out);
    porta_dir <= 8'hFF;
    porta_out <= 8'h5A;
    for (d = 0; d < 4; d++) begin
      bus(1'b1, PAB_ADDR_LCD, 8'h80 | 8'(d));
      settle;
      ex = {4'hF, d > 2, d > 1, d > 0, 1'b1};
      chk("lcd en", ex, porta_analog_en);
      chk("lcd oe", {24'h0, ~ex}, porta_pad_oe);
      chk("lcd in", 8'h5A & ~ex, porta_in);
      chk("lcd aio", 32'h96, porta_analog_out);
    end
    bus(1'b1, PAB_ADDR_LCD, 8'h00);
    portb_dir <= 8'hF0;
    cmp_en <= 4'hF;
    cmp_val <= 4'hA;
    settle;
    chk("cmp out", 32'hA, portb_pad_out[7:4]);
    cmp_val <= 4'h5;
    settle;
    chk("pwm out", 32'h5, portb_pad_out[7:4]);
    portb_dir <= 8'hFF;
    spi_master_out <= 1'b1;
    bus(1'b1, PAB_ADDR_SPI, 8'h03);
    settle;
    chk("master oe", 32'h7, portb_pad_oe[3:0]);
    chk("master out", 32'h2, portb_pad_out[2:1]);
    bus(1'b1, PAB_ADDR_SPI, 8'h02);
    settle;
    chk("slave oe", 32'h8, portb_pad_oe[3:0]);
    portb_dir <= 8'h0F;
    settle;
    chk("slave pull", 32'h7, portb_pullup[3:0]);
    bus(1'b1, PAB_ADDR_SPI, 8'h03);
    settle;
    chk("master pull", 32'h8, portb_pullup[3:0]);
    bus(1'b1, PAB_ADDR_CTRL, 8'h10);
    settle;
    chk("master pud", 32'h0, portb_pullup[3:0]);
    bus(1'b1, PAB_ADDR_CTRL, 8'h00);
    bus(1'b1, PAB_ADDR_SPI, 8'h00);
    portb_dir <= 8'h00;
    ext_en <= 8'hFF;
    ext_val <= 8'hB4;
    settle;
    chk("pin change", 32'h5A, pin_change_source);
    chk("select", 32'h0, spi_slave_select_n);
    chk("miso in", 32'h0, spi_master_in);
    chk("mosi in", 32'h1, spi_slave_in);
    chk("sck in", 32'h0, spi_sck_in);
    bus(1'b0, PAB_ADDR_STAT, 8'h00);
    chk("status", 32'hB4, rd);
    sleep <= 1'b1;
    settle;
    chk("sleep in", 32'h00, portb_in);
    pin_change_mask <= 8'hFE;
    pin_change_group_enable <= 1'b1;
    settle;
    chk("wake in", 32'hB4, portb_in);
    conclude;
  end
endmodule : tb_pab_top

// ===== hw/pab_pin.sv
// One pad cell: override muxing and two-flop input synchroniser
`timescale 1ns/1ps
module pab_pin (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_direction_bit,
  input wire logic pin_output_bit,
  input wire logic global_pullup_off,
  input wire logic sleep,
  input wire logic pullup_override_en,
  input wire logic pullup_override_val,
  input wire logic dir_override_en,
  input wire logic dir_override_val,
  input wire logic value_override_en,
  input wire logic value_override_val,
  input wire logic input_gate_override_en,
  input wire logic input_gate_override_val,
  input wire logic pad_in,
  output logic pad_out_q,
  output logic pad_oe_q,
  output logic pullup_q,
  output logic sync_q
);
  logic pu_d;
  logic oe_d;
  logic out_d;
  logic die_d;
  logic meta_q;
  logic hold_q;

  // Override muxes for one pad
  always_comb begin
    pu_d = pullup_override_en ? pullup_override_val // [R12]
         : (!pin_direction_bit && pin_output_bit
            && !global_pullup_off); // [R1] [R12] [R16]
    oe_d = dir_override_en ? dir_override_val
         : pin_direction_bit; // [R13] [R16]
    out_d = value_override_en ? value_override_val
          : pin_output_bit; // [R5] [R6]
    die_d = input_gate_override_en ? input_gate_override_val
          : !sleep; // [R14]
  end

  // Registered pad controls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
      pullup_q <= 1'b0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      pullup_q <= pu_d;
    end
  end

  // Two-flop synchroniser, then the gate; gated input reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      hold_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pad_in;
      hold_q <= meta_q;
      sync_q <= hold_q & die_d; // [R14]
    end
  end
endmodule : pab_pin

// ===== hw/pab_pkg.sv
// Constants for the port A/B override block and its register map
// Summary of operation
// R1 - Global pull-up disable set turns every port pull-up off
// R2 - Port A 7:4 carry LCD segments 3:0, 3:0 carry commons 3:0
// R3 - LCD enabled: port A 7:4 pull-up, driver and input forced off
// R4 - Port A 3..1 overridden when duty field exceeds 2,1,0; bit 0 always
// R5 - Port B 7:4 output timer compares when direction bit set
// R6 - Same pins carry the timer PWM waveform in PWM modes
// R7 - SPI master forces port B bit 3 to input; slave follows direction
// R8 - SPI slave forces port B bit 2 to input; master follows direction
// R9 - SPI slave forces port B bit 1 to input; master follows direction
// R10 - Forced SPI input pins keep pull-up under their output bit
// R11 - Port B 7:1 feed pin-change sources 15:9 with digital input
// R12 - Pull-up override wins; else pull-up on when dir,out,off = 0,1,0
// R13 - Direction override value replaces direction bit when enabled
// R14 - Input gate override value wins over sleep state when enabled
// R15 - Port B bit 0 is the active-low SPI slave select input
// R16 - Without overrides a pin is a plain general-purpose I/O
// R17 - Unused control bits read zero; implemented bits reset to zero
package pab_pkg;
  localparam int PAB_AW = 2;
  // Word addresses of the registers
  localparam logic [1:0] PAB_ADDR_CTRL = 2'h0;
  localparam logic [1:0] PAB_ADDR_LCD = 2'h1;
  localparam logic [1:0] PAB_ADDR_SPI = 2'h2;
  localparam logic [1:0] PAB_ADDR_STAT = 2'h3;
  // Control register fields
  localparam int PAB_BIT_JTD = 7;
  localparam int PAB_BIT_PUOFF = 4;
  localparam int PAB_BIT_IVSEL = 1;
  localparam int PAB_BIT_IVCE = 0;
  localparam logic [7:0] PAB_CTRL_MASK = 8'h93;
  localparam logic [7:0] PAB_CTRL_RST = 8'h00;
  // LCD register fields
  localparam int PAB_BIT_LCD_ENABLE = 7;
  localparam int PAB_LCD_DUTY_LSB = 0;
  localparam logic [7:0] PAB_LCD_MASK = 8'h83;
  // SPI mode register fields
  localparam int PAB_BIT_SPE = 1;
  localparam int PAB_BIT_SPI_MASTER_SELECT = 0;
  localparam logic [7:0] PAB_SPI_MASK = 8'h03;
  localparam logic [31:0] PAB_UNMAPPED = 32'h0000_0000;
  // Port B pin positions
  localparam int PAB_MISO = 3;
  localparam int PAB_MOSI = 2;
  localparam int PAB_SCK = 1;
  localparam int PAB_SS = 0;
endpackage : pab_pkg

// ===== hw/pab_top.sv
// Port A/B pin override block with Avalon-MM control registers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module pab_top
  import pab_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] porta_dir,
  input wire logic [7:0] porta_out,
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portb_out,
  input wire logic sleep,
  input wire logic [7:0] pin_change_mask,
  input wire logic pin_change_group_enable,
  input wire logic t2_compare_a_en,
  input wire logic t2_compare_a_out,
  input wire logic t1_compare_b_en,
  input wire logic t1_compare_b_out,
  input wire logic t1_compare_a_en,
  input wire logic t1_compare_a_out,
  input wire logic t0_compare_a_en,
  input wire logic t0_compare_a_out,
  input wire logic spi_slave_out,
  input wire logic spi_master_out,
  input wire logic spi_sck_out,
  input wire logic [3:0] lcd_segment_line,
  input wire logic [3:0] lcd_common_line,
  input wire logic [7:0] porta_pad_in,
  input wire logic [7:0] portb_pad_in,
  output logic [7:0] porta_pad_out,
  output logic [7:0] porta_pad_oe,
  output logic [7:0] porta_pullup,
  output logic [7:0] porta_analog_en,
  output logic [7:0] porta_analog_out,
  output logic [7:0] portb_pad_out,
  output logic [7:0] portb_pad_oe,
  output logic [7:0] portb_pullup,
  output logic [7:0] porta_in,
  output logic [7:0] portb_in,
  output logic [7:1] pin_change_source,
  output logic spi_master_in,
  output logic spi_slave_in,
  output logic spi_sck_in,
  output logic spi_slave_select_n
);
  // Register state and decoded controls
  logic [7:0] ctrl_q;
  logic [7:0] lcd_q;
  logic [7:0] spi_q;
  logic wr_en;
  logic global_pullup_off;
  logic lcd_enable;
  logic [1:0] lcd_duty_select;
  logic spi_enable_bit;
  logic spi_master_select;
  logic spi_m;
  logic spi_s;
  logic [7:0] a_ovr;
  logic [7:0] b_pullup_override_en;
  logic [7:0] b_pullup_override_val;
  logic [7:0] b_dir_override_en;
  logic [7:0] b_value_override_en;
  logic [7:0] b_value_override_val;
  logic [7:0] b_input_gate_override_en;
  logic [7:0] a_sync;
  logic [7:0] b_sync;
  logic [7:0] a_ana_d;
  logic [7:0] a_aout_d;
  logic [7:0] stat_d;
  logic [31:0] rdata_d;

  // Register fields and SPI mode decode
  assign global_pullup_off = ctrl_q[PAB_BIT_PUOFF];
  assign lcd_enable = lcd_q[PAB_BIT_LCD_ENABLE];
  assign lcd_duty_select = lcd_q[PAB_LCD_DUTY_LSB +: 2];
  assign spi_enable_bit = spi_q[PAB_BIT_SPE];
  assign spi_master_select = spi_q[PAB_BIT_SPI_MASTER_SELECT];
  assign spi_m = spi_enable_bit & spi_master_select;
  assign spi_s = spi_enable_bit & !spi_master_select;

  // Bus slave: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Write lands at the edge where waitrequest is sampled low
  assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Control register, masked to implemented bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= PAB_CTRL_RST; // [R17]
    end else if (wr_en && (avs_address == PAB_ADDR_CTRL)) begin
      ctrl_q <= avs_writedata[7:0] & PAB_CTRL_MASK; // [R17]
    end
  end

  // LCD register, enable and duty field
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lcd_q <= PAB_CTRL_RST;
    end else if (wr_en && (avs_address == PAB_ADDR_LCD)) begin
      lcd_q <= avs_writedata[7:0] & PAB_LCD_MASK;
    end
  end

  // SPI mode register, enable and master select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spi_q <= PAB_CTRL_RST;
    end else if (wr_en && (avs_address == PAB_ADDR_SPI)) begin
      spi_q <= avs_writedata[7:0] & PAB_SPI_MASK;
    end
  end

  // Status: pins' synchronised input values of port B
  assign stat_d = b_sync;

  // Read data mux over the four registers
  always_comb begin
    if (avs_address == PAB_ADDR_CTRL) begin
      rdata_d = {24'h000000, ctrl_q};
    end else if (avs_address == PAB_ADDR_LCD) begin
      rdata_d = {24'h000000, lcd_q};
    end else if (avs_address == PAB_ADDR_SPI) begin
      rdata_d = {24'h000000, spi_q};
    end else if (avs_address == PAB_ADDR_STAT) begin
      rdata_d = {24'h000000, stat_d};
    end else begin
      rdata_d = PAB_UNMAPPED;
    end
  end

  // Read data captured in the wait cycle, stands when waitrequest drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= PAB_UNMAPPED;
    end else begin
      avs_readdata <= rdata_d;
    end
  end

  // Port A LCD override enables per pin
  always_comb begin
    a_ovr[7:4] = {4{lcd_enable}}; // [R3]
    a_ovr[3] = lcd_enable && (lcd_duty_select > 2'h2); // [R4]
    a_ovr[2] = lcd_enable && (lcd_duty_select > 2'h1); // [R4]
    a_ovr[1] = lcd_enable && (lcd_duty_select > 2'h0); // [R4]
    a_ovr[0] = lcd_enable; // [R4]
  end

  // Port B override enables and values
  always_comb begin
    b_pullup_override_en = '0;
    b_pullup_override_val = '0;
    b_dir_override_en = '0;
    b_value_override_en = {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en,
              t0_compare_a_en, 4'h0}; // [R5] [R6]
    b_value_override_val = {t2_compare_a_out, t1_compare_b_out, t1_compare_a_out,
              t0_compare_a_out, 4'h0}; // [R5] [R6]
    // Master drives MOSI and SCK, slave drives MISO
    b_dir_override_en[PAB_MISO] = spi_m; // [R7]
    b_dir_override_en[PAB_MOSI] = spi_s; // [R8]
    b_dir_override_en[PAB_SCK] = spi_s; // [R9]
    b_dir_override_en[PAB_SS] = spi_s; // [R15]
    b_value_override_en[PAB_MISO] = spi_s;
    b_value_override_val[PAB_MISO] = spi_slave_out;
    b_value_override_en[PAB_MOSI] = spi_m;
    b_value_override_val[PAB_MOSI] = spi_master_out;
    b_value_override_en[PAB_SCK] = spi_m;
    b_value_override_val[PAB_SCK] = spi_sck_out;
    // Forced SPI inputs keep a pull-up under their output bit
    b_pullup_override_en[PAB_MISO] = spi_m; // [R10]
    b_pullup_override_en[PAB_MOSI] = spi_s; // [R10]
    b_pullup_override_en[PAB_SCK] = spi_s; // [R10]
    b_pullup_override_en[PAB_SS] = spi_s; // [R10]
    b_pullup_override_val[PAB_MISO:PAB_SS] = portb_out[PAB_MISO:PAB_SS]
                            & {4{!global_pullup_off}}; // [R1] [R10]
    // Pin-change enables keep inputs alive in sleep
    b_input_gate_override_en = pin_change_mask & {8{pin_change_group_enable}}; // [R11]
  end

  // Analog pad path for LCD lines
  always_comb begin
    a_ana_d = a_ovr; // [R2]
    a_aout_d = {lcd_segment_line, lcd_common_line}; // [R2]
  end

  // LCD analog enables per pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      porta_analog_en <= 8'h00;
    end else begin
      porta_analog_en <= a_ana_d; // [R2]
    end
  end

  // LCD drive levels onto the pads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      porta_analog_out <= 8'h00;
    end else begin
      porta_analog_out <= a_aout_d; // [R2]
    end
  end

  // One pad cell per pin for both ports
  for (genvar i = 0; i < 8; i++) begin : g_pin
    pab_pin u_a (
      .clock(clock),
      .rst_n(rst_n),
      .pin_direction_bit(porta_dir[i]),
      .pin_output_bit(porta_out[i]),
      .global_pullup_off(global_pullup_off), // [R1]
      .sleep(sleep),
      .pullup_override_en(a_ovr[i]), // [R3] [R4]
      .pullup_override_val(1'b0),
      .dir_override_en(a_ovr[i]),
      .dir_override_val(1'b0),
      .value_override_en(1'b0),
      .value_override_val(1'b0),
      .input_gate_override_en(a_ovr[i]),
      .input_gate_override_val(1'b0),
      .pad_in(porta_pad_in[i]),
      .pad_out_q(porta_pad_out[i]),
      .pad_oe_q(porta_pad_oe[i]),
      .pullup_q(porta_pullup[i]),
      .sync_q(a_sync[i])
    );
    pab_pin u_b (
      .clock(clock),
      .rst_n(rst_n),
      .pin_direction_bit(portb_dir[i]),
      .pin_output_bit(portb_out[i]),
      .global_pullup_off(global_pullup_off),
      .sleep(sleep),
      .pullup_override_en(b_pullup_override_en[i]),
      .pullup_override_val(b_pullup_override_val[i]),
      .dir_override_en(b_dir_override_en[i]),
      .dir_override_val(1'b0),
      .value_override_en(b_value_override_en[i]),
      .value_override_val(b_value_override_val[i]),
      .input_gate_override_en(b_input_gate_override_en[i]),
      .input_gate_override_val(1'b1), // [R14]
      .pad_in(portb_pad_in[i]),
      .pad_out_q(portb_pad_out[i]),
      .pad_oe_q(portb_pad_oe[i]),
      .pullup_q(portb_pullup[i]),
      .sync_q(b_sync[i])
    );
  end

  // Gated port inputs towards the core
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      porta_in <= 8'h00;
      portb_in <= 8'h00;
    end else begin
      porta_in <= a_sync;
      portb_in <= b_sync;
    end
  end

  // Pin-change sources from port B bits 7 to 1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_source <= 7'h00;
    end else begin
      pin_change_source <= b_sync[7:1]; // [R11]
    end
  end

  // SPI data and clock inputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spi_master_in <= 1'b0;
      spi_slave_in <= 1'b0;
      spi_sck_in <= 1'b0;
    end else begin
      spi_master_in <= b_sync[PAB_MISO];
      spi_slave_in <= b_sync[PAB_MOSI];
      spi_sck_in <= b_sync[PAB_SCK];
    end
  end

  // Slave select, idle high out of reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spi_slave_select_n <= 1'b1;
    end else begin
      spi_slave_select_n <= b_sync[PAB_SS]; // [R15]
    end
  end
endmodule : pab_top
